// ---- core/asrh_host.sv ----
// Host controller that reads the serial sampling converter
`timescale 1ns/1ps
`default_nettype none
module asrh_host (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire asrh_pkg::asrh_mode_t mode,
  input  wire logic                 start,
  input  wire logic                 power_down,
  input  wire logic [15:0]          interval_sclks,
  input  wire logic                 serial_result_out,
  output logic                      sclk_out,
  output logic                      host_transmit_frame_n,
  output logic                      conversion_start_strobe_n,
  output asrh_pkg::asrh_result_t    result_out,
  output logic                      busy
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_STROBE = 5'h02,
    ST_WAIT   = 5'h04,
    ST_SHIFT  = 5'h08,
    ST_DONE   = 5'h10
  } asrh_state_t;

  asrh_state_t                     state_reg;
  logic [asrh_pkg::CNT_W-1:0]      cnt_reg;
  logic [asrh_pkg::CNT_W-1:0]      half_reg;
  logic [asrh_pkg::BIT_CNT_W-1:0]  bits_reg;
  logic [asrh_pkg::BIT_CNT_W-1:0]  len_reg;
  logic [asrh_pkg::WORD_BITS-1:0]  shift_reg;
  logic                            sd_meta_reg;
  logic                            sd_sync_reg;
  logic                            gap_reg;
  logic [15:0]                     tick_reg;
  logic                            tick_due_reg;
  logic                            half_end;
  logic                            half_tick;
  logic                            tick_set;

  localparam logic [asrh_pkg::CNT_W-1:0] HALF_LAST =
    asrh_pkg::CNT_W'(asrh_pkg::HALF_CYC - 1);
  localparam logic [asrh_pkg::CNT_W-1:0] WAIT_LAST =
    asrh_pkg::CNT_W'(asrh_pkg::CONV_WAIT_CYC - 1);
  localparam logic [asrh_pkg::CNT_W-1:0] STROBE_LAST =
    asrh_pkg::CNT_W'(asrh_pkg::STROBE_CYC - 1);
  localparam logic [asrh_pkg::BIT_CNT_W-1:0] LEN_FULL =
    asrh_pkg::BIT_CNT_W'(asrh_pkg::WORD_BITS);
  localparam logic [asrh_pkg::BIT_CNT_W-1:0] LEN_SHORT =
    asrh_pkg::BIT_CNT_W'(asrh_pkg::SHORT_BITS);

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  // Frame start, shared by the sequencer and the pending-tick flag
  function automatic logic frame_take(input asrh_state_t st,
                                      input logic        go,
                                      input logic        due,
                                      input logic        slot);
    frame_take = (st == ST_IDLE) && go && due && slot;
  endfunction : frame_take

  // ----------------------------------------
  // Data input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end else begin
      sd_meta_reg <= serial_result_out;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  // ----------------------------------------
  // Sample-rate divider
  // ----------------------------------------
  // Half-period pulse paces the serial clock; every second ends a period
  always_ff @(posedge clk) begin
    if (reset) begin
      half_reg <= '0;
      gap_reg  <= 1'b0;
    end else begin
      half_reg <= half_tick ? '0 : half_reg + 1'b1;
      if (half_tick) begin
        gap_reg <= ~gap_reg;
      end
    end
  end

  assign half_tick = (half_reg == HALF_LAST);
  assign half_end  = half_tick && gap_reg;
  // Counted in whole serial clock periods so frames never slip an edge
  assign tick_set  = half_end &&
                     (tick_reg >= interval_sclks - 16'h0001);

  // Interval of zero behaves as the longest interval
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_reg <= 16'h0000;
    end else if (tick_set) begin
      tick_reg <= 16'h0000;
    end else if (half_end) begin
      tick_reg <= tick_reg + 16'h0001;
    end
  end

  // Tick stays pending until a frame takes it; a fresh tick wins
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_due_reg <= 1'b0;
    end else if (tick_set) begin
      tick_due_reg <= 1'b1;
    end else if (frame_take(state_reg, start, tick_due_reg, half_end)) begin
      tick_due_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg                 <= ST_IDLE;
      cnt_reg                   <= '0;
      bits_reg                  <= '0;
      len_reg                   <= LEN_FULL;
      shift_reg                 <= 16'h0000;
      sclk_out                  <= 1'b1;
      host_transmit_frame_n     <= 1'b1;
      conversion_start_strobe_n <= 1'b1;
      result_out                <= '0;
      busy                      <= 1'b0;
    end else begin
      result_out.valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          sclk_out <= 1'b1;
          busy     <= 1'b0;
          if (frame_take(state_reg, start, tick_due_reg, half_end)) begin
            busy     <= 1'b1;
            bits_reg <= '0;
            cnt_reg  <= '0;
            if (mode == asrh_pkg::MODE_HOST_CLOCKED) begin
              len_reg  <= power_down ? LEN_SHORT : LEN_FULL;
              host_transmit_frame_n <= 1'b0;
              state_reg <= ST_SHIFT;
            end else begin
              len_reg  <= LEN_FULL;
              conversion_start_strobe_n <= 1'b0;
              state_reg <= ST_STROBE;
            end
          end
        end
        ST_STROBE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == STROBE_LAST) begin
            conversion_start_strobe_n <= 1'b1;
            cnt_reg   <= '0;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Counted after the strobe rises, so the wait is generous
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == WAIT_LAST) begin
            cnt_reg   <= '0;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // Host is master: clock made from the half-period pulse
          if (half_tick) begin
            if (sclk_out) begin
              sclk_out <= 1'b0;
              // Falling edge: take the bit already presented, MSB first
              // Bit must settle two clocks before the fall
              shift_reg <= {shift_reg[asrh_pkg::WORD_BITS-2:0],
                            sd_sync_reg};
              bits_reg  <= bits_reg + 1'b1;
            end else if (bits_reg == len_reg) begin
              sclk_out  <= 1'b1;
              state_reg <= ST_DONE;
            end else begin
              sclk_out <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          host_transmit_frame_n <= 1'b1;
          // Power-down frames carry no result
          if (len_reg == LEN_FULL) begin
            // Leading zeros dropped; result right-justified
            result_out.result <=
              shift_reg[asrh_pkg::RESULT_BITS-1:0];
            result_out.valid  <= 1'b1;
          end
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : asrh_host
`default_nettype wire

// ---- core/asrh_pkg.sv ----
// Package for the converter serial readout host
package asrh_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ         = 20000000;
  localparam int CLK_NS         = 50;
  // Wait after strobe falls before reading, in ns (3.3 us)
  localparam int CONV_WAIT_NS   = 3300;
  localparam int CONV_WAIT_CYC  = (CONV_WAIT_NS + CLK_NS - 1) / CLK_NS;
  // Strobe low time, in ns
  localparam int STROBE_NS      = 100;
  localparam int STROBE_CYC     = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Half serial clock period in system cycles (SCLK = 2 MHz)
  localparam int HALF_CYC       = 5;
  localparam int CNT_W          = 8;
  // ----------------------------------------
  // Word format
  // ----------------------------------------
  localparam int WORD_BITS      = 16;
  localparam int SHORT_BITS     = 8;
  localparam int RESULT_BITS    = 12;
  localparam int BIT_CNT_W      = 5;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_CONV_TIMED  = 2'h0,
    MODE_HOST_CLOCKED = 2'h1
  } asrh_mode_t;

  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic strobe_n;
  } asrh_pins_t;

  typedef struct packed {
    logic [RESULT_BITS-1:0] result;
    logic                   valid;
  } asrh_result_t;
endpackage : asrh_pkg

// ---- tb/asrh_conv_model.sv ----
// Behavioural model of the serial sampling converter
`timescale 1ns/1ps
`default_nettype none
module asrh_conv_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic strobe_n,
  input wire logic [11:0] code,
  output logic sdo
);
  logic [15:0] word_reg = 16'h0000;
  logic last_reg = 1'b0;
  // First bit out at once, zeros lead
  always @(negedge strobe_n or negedge cs_n)
    word_reg = {4'h0, code};
  // Shift on rise so bit is steady at host fall
  always @(posedge sclk)
    if (!cs_n) word_reg = {word_reg[14:0], 1'b0};
  // Released line shows inverse, never a held value
  always @* begin
    if (cs_n) sdo = ~last_reg;
    else begin
      sdo = word_reg[15];
      last_reg = word_reg[15];
    end
  end
endmodule : asrh_conv_model
`default_nettype wire

// ---- tb/asrh_properties.sv ----
// Port timing checker for the converter readout host
`timescale 1ns/1ps
`default_nettype none
module asrh_properties (
  input wire logic clk,
  input wire logic reset,
  input wire asrh_pkg::asrh_mode_t mode,
  input wire logic start,
  input wire logic power_down,
  input wire logic [15:0] interval_sclks,
  input wire logic serial_result_out,
  input wire logic sclk_out,
  input wire logic host_transmit_frame_n,
  input wire logic conversion_start_strobe_n,
  input wire asrh_pkg::asrh_result_t result_out,
  input wire logic busy
);
  logic [7:0] since_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Cycles since strobe was last low, saturating
  always_ff @(posedge clk)
    if (reset) since_reg <= 8'hFF;
    else if (!conversion_start_strobe_n) since_reg <= 8'h00;
    else if (since_reg != 8'hFF) since_reg <= since_reg + 8'h01;
  a_idle_clk_high: assert property (!busy |-> sclk_out)
    else $error("serial clock low while idle");
  a_select_in_word: assert property (!host_transmit_frame_n |-> busy)
    else $error("select low outside a transfer");
  a_first_fall: assert property ($fell(host_transmit_frame_n) |->
    sclk_out [*5] ##1 !sclk_out) else $error("first fall misplaced");
  a_frame_held: assert property ($fell(host_transmit_frame_n) |=>
    !host_transmit_frame_n [*8]) else $error("select dropped early");
  a_half_period: assert property ($fell(sclk_out) |=>
    !sclk_out [*4] ##1 sclk_out) else $error("serial clock low time");
  // Two strobe cycles already counted before the count starts
  a_conv_wait: assert property ($fell(sclk_out) && host_transmit_frame_n
    |-> since_reg >= 8'h40) else $error("read started too early");
  a_strobe_pulse: assert property ($fell(conversion_start_strobe_n)
    |=> !conversion_start_strobe_n ##1 conversion_start_strobe_n)
    else $error("strobe width");
  a_valid_pulse: assert property (result_out.valid |->
    host_transmit_frame_n && sclk_out ##1 !result_out.valid)
    else $error("result pulse misplaced");
endmodule : asrh_properties
bind asrh_host asrh_properties asrh_properties_i (.clk(clk), .reset(reset),
  .mode(mode), .start(start), .power_down(power_down),
  .interval_sclks(interval_sclks), .serial_result_out(serial_result_out),
  .sclk_out(sclk_out), .host_transmit_frame_n(host_transmit_frame_n),
  .conversion_start_strobe_n(conversion_start_strobe_n),
  .result_out(result_out), .busy(busy));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the converter readout host
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, reset = 1'b1, start = 1'b0, power_down = 1'b0;
  asrh_pkg::asrh_mode_t mode = asrh_pkg::MODE_HOST_CLOCKED;
  logic [15:0] interval_sclks = 16'h0028;
  logic [11:0] code = 12'h000;
  logic sdo, sclk_out, frame_n, strobe_n, busy, fr_q = 1'b1, sc_q = 1'b1;
  asrh_pkg::asrh_result_t result_out;
  int n_mismatch = 0, n_checks = 0, cyc = 0, falls = 0, t_fr = 0, gap = 0;
  int nfr = 0, nst = 0;
  logic st_q = 1'b1;
  always #25 clk = ~clk;
  asrh_host asrh_host_i (.clk(clk), .reset(reset), .mode(mode),
    .start(start), .power_down(power_down), .interval_sclks(interval_sclks),
    .serial_result_out(sdo), .sclk_out(sclk_out),
    .host_transmit_frame_n(frame_n), .conversion_start_strobe_n(strobe_n),
    .result_out(result_out), .busy(busy));
  // Select tied low in the converter-timed mode
  asrh_conv_model asrh_conv_model_i (.sclk(sclk_out), .strobe_n(strobe_n),
    .cs_n(mode == asrh_pkg::MODE_HOST_CLOCKED ? frame_n : 1'b0),
    .code(code), .sdo(sdo));
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask : check
  always @(negedge clk) begin
    cyc++;
    if (fr_q && !frame_n) begin
      gap = cyc - t_fr;
      t_fr = cyc;
      nfr++;
    end
    if (sc_q && !sclk_out) falls++;
    if (st_q && !strobe_n) nst++;
    st_q = strobe_n;
    fr_q = frame_n;
    sc_q = sclk_out;
  end
  always @(negedge clk) if (cyc == 20000) begin
    n_mismatch++;
    final_report();
  end
  task automatic xfer(input asrh_pkg::asrh_mode_t m, input logic pd,
                      input logic [11:0] c);
    int k;
    int idle;
    int f0;
    int s0;
    logic got;
    logic host;
    got = 1'b0;
    idle = 0;
    f0 = nfr;
    s0 = nst;
    host = (m == asrh_pkg::MODE_HOST_CLOCKED);
    mode = m;
    power_down = pd;
    code = c;
    start = 1'b1;
    for (k = 0; k < 600 && busy !== 1'b1; k++) @(negedge clk);
    start = 1'b0;
    falls = 0;
    for (k = 0; k < 800 && idle < 4; k++) begin
      @(negedge clk);
      if (result_out.valid === 1'b1) begin
        got = 1'b1;
        check({4'h0, result_out.result}, {4'h0, c});
      end
      idle = busy ? 0 : idle + 1;
    end
    check(16'(falls), pd ? 16'h0008 : 16'h0010);
    check({15'h0000, got}, {15'h0000, ~pd});
    check(16'(nfr - f0), {15'h0000, host});
    check(16'(nst - s0), {15'h0000, ~host});
  endtask : xfer
  // Three frames back to back, spacing from the last pair
  task automatic equi;
    int k;
    int n0;
    n0 = nfr;
    mode = asrh_pkg::MODE_HOST_CLOCKED;
    start = 1'b1;
    for (k = 0; k < 1500 && nfr < n0 + 3; k++) @(negedge clk);
    start = 1'b0;
    check(16'(gap), interval_sclks * 16'(2 * asrh_pkg::HALF_CYC));
  endtask : equi
  initial begin
    repeat (20) @(negedge clk);
    check({11'h000, sclk_out, frame_n, strobe_n, busy, result_out.valid},
          16'h001C);
    reset = 1'b0;
    xfer(asrh_pkg::MODE_HOST_CLOCKED, 1'b0, 12'hA5C);
    xfer(asrh_pkg::MODE_HOST_CLOCKED, 1'b1, 12'h3C1);
    xfer(asrh_pkg::MODE_CONV_TIMED, 1'b0, 12'h801);
    xfer(asrh_pkg::MODE_HOST_CLOCKED, 1'b0, 12'hFFF);
    equi();
    final_report();
  end
endmodule : tb
`default_nettype wire
